//--- hw/mttc_ctrl.sv
`timescale 1ns/10ps
`include "mttc_cfg.svh"


module mttc_ctrl import mttc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `MTTC_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [`MTTC_ADDR_W-1:0] reg_addr,
  input wire logic [`MTTC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`MTTC_DATA_W-1:0] reg_rdata,
  input wire logic signed [`MTTC_WT_W-1:0] gross_weight,
  input wire logic signed [`MTTC_WT_W-1:0] net_weight,
  input wire logic start_pin,
  input wire logic pause_pin,
  input wire logic resume_pin,
  input wire logic abort_pin,
  output logic feed_out,
  output logic fast_feed_out,
  output logic running_out
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic signed [`MTTC_AR_W-1:0] mttc_ext(input logic signed [`MTTC_WT_W-1:0] v);
    return {{(`MTTC_AR_W - `MTTC_WT_W){v[`MTTC_WT_W-1]}}, v};
  endfunction

  function automatic logic mttc_hit(input logic [`MTTC_ADDR_W-1:0] a, input logic [`MTTC_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [`MTTC_CTRL_W-1:0] ctrl_reg;
  logic signed [`MTTC_WT_W-1:0] target_reg;
  logic signed [`MTTC_WT_W-1:0] spill_reg;
  logic signed [`MTTC_WT_W-1:0] fine_reg;
  logic signed [`MTTC_WT_W-1:0] target_act_reg;
  logic signed [`MTTC_WT_W-1:0] spill_act_reg;
  logic signed [`MTTC_WT_W-1:0] fine_act_reg;
  logic signed [`MTTC_WT_W-1:0] base_reg;
  logic signed [`MTTC_AR_W-1:0] sample_reg;
  logic eval_reg;
  logic [`MTTC_PIN_N-1:0] pin_meta_reg;
  logic [`MTTC_PIN_N-1:0] pin_sync_reg;
  logic [`MTTC_PIN_N-1:0] pin_last_reg;
  logic [`MTTC_PIN_N-1:0] pin_raw;
  logic [`MTTC_PIN_N-1:0] pin_rise;
  mttc_state_type state_reg;
  mttc_state_type state_next;
  mttc_state_type resume_reg;
  logic feed_reg;
  logic feed_next;
  logic fast_reg;
  logic fast_next;
  logic running_reg;
  logic [`MTTC_DATA_W-1:0] rdata_reg;
  logic [`MTTC_DATA_W-1:0] rdata_next;
  logic tick;

  wire mode_latched = ctrl_reg[`MTTC_CTRL_LATCHED];
  wire use_net = ctrl_reg[`MTTC_CTRL_USE_NET];
  wire two_speed = ctrl_reg[`MTTC_CTRL_TWO_SPEED];
  wire independent = ctrl_reg[`MTTC_CTRL_INDEP];
  wire weigh_out = ctrl_reg[`MTTC_CTRL_WEIGH_OUT];
  wire signed [`MTTC_WT_W-1:0] sel_weight = use_net ? net_weight : gross_weight;

  // ==========================================================================
  // Comparison rate
  // ==========================================================================
  mttc_tick #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  // ==========================================================================
  // Discrete control inputs
  // ==========================================================================
  // Pins are asynchronous, so each passes two flops before the edge detector.
  assign pin_raw = {abort_pin, resume_pin, pause_pin, start_pin};
  assign pin_rise = pin_sync_reg & ~pin_last_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `MTTC_PIN_N; gi = gi + 1) begin : g_pin
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
          pin_last_reg[gi] <= 1'b0;
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
          pin_last_reg[gi] <= pin_sync_reg[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Register writes and commands
  // ==========================================================================
  wire wr_ctrl = reg_wr && mttc_hit(reg_addr, `MTTC_OFS_CTRL);
  wire wr_target = reg_wr && mttc_hit(reg_addr, `MTTC_OFS_TARGET);
  wire wr_spill = reg_wr && mttc_hit(reg_addr, `MTTC_OFS_SPILL);
  wire wr_fine = reg_wr && mttc_hit(reg_addr, `MTTC_OFS_FINE);
  wire wr_cmd = reg_wr && mttc_hit(reg_addr, `MTTC_OFS_CMD);

  wire start_req = (wr_cmd && reg_wdata[`MTTC_CMD_START]) || pin_rise[`MTTC_CMD_START];
  wire pause_req = (wr_cmd && reg_wdata[`MTTC_CMD_PAUSE]) || pin_rise[`MTTC_CMD_PAUSE];
  wire resume_req = (wr_cmd && reg_wdata[`MTTC_CMD_RESUME]) || pin_rise[`MTTC_CMD_RESUME];
  wire abort_req = (wr_cmd && reg_wdata[`MTTC_CMD_ABORT]) || pin_rise[`MTTC_CMD_ABORT];

  wire start_ok = mode_latched && start_req && (state_reg == MTTC_IDLE || state_reg == MTTC_DONE);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `MTTC_CTRL_RST;
      target_reg <= `MTTC_WT_RST;
      spill_reg <= `MTTC_WT_RST;
      fine_reg <= `MTTC_WT_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata[`MTTC_CTRL_W-1:0];
      if (wr_target) target_reg <= reg_wdata[`MTTC_WT_W-1:0];
      if (wr_spill) spill_reg <= reg_wdata[`MTTC_WT_W-1:0];
      if (wr_fine) fine_reg <= reg_wdata[`MTTC_WT_W-1:0];
    end
  end

  // Targets are copied only on start, so edits during a run or a pause
  // take effect at the next start and never disturb a resumed fill.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      target_act_reg <= `MTTC_WT_RST;
      spill_act_reg <= `MTTC_WT_RST;
      fine_act_reg <= `MTTC_WT_RST;
      base_reg <= `MTTC_WT_RST;
    end else if (start_ok) begin
      target_act_reg <= target_reg;
      spill_act_reg <= spill_reg;
      fine_act_reg <= fine_reg;
      base_reg <= sel_weight;
    end
  end

  // ==========================================================================
  // Weight sampling and thresholds
  // ==========================================================================
  // A weigh-out measures material removed since start, so it rises like a fill.
  wire signed [`MTTC_AR_W-1:0] moved = weigh_out ? mttc_ext(base_reg) - mttc_ext(sel_weight)
                                                : mttc_ext(sel_weight);
  wire signed [`MTTC_WT_W-1:0] cur_target = mode_latched ? target_act_reg : target_reg;
  wire signed [`MTTC_WT_W-1:0] cur_spill = mode_latched ? spill_act_reg : spill_reg;
  wire signed [`MTTC_WT_W-1:0] cur_fine = mode_latched ? fine_act_reg : fine_reg;
  wire signed [`MTTC_AR_W-1:0] cut_final = mttc_ext(cur_target) - mttc_ext(cur_spill);
  wire signed [`MTTC_AR_W-1:0] cut_fast = cut_final - mttc_ext(cur_fine);
  wire below_final = sample_reg < cut_final;
  wire above_final = sample_reg > cut_final;
  wire below_fast = sample_reg < cut_fast;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_reg <= 26'h0;
      eval_reg <= 1'b0;
    end else begin
      if (tick) sample_reg <= moved;
      eval_reg <= tick;
    end
  end

  // ==========================================================================
  // Feeder sequence
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MTTC_IDLE, MTTC_DONE: begin
        if (start_ok) begin
          state_next = two_speed ? MTTC_RAPID : MTTC_SLOW;
        end
      end
      MTTC_RAPID: begin
        if (pause_req) begin
          state_next = MTTC_PAUSED;
        end else if (eval_reg && !below_final) begin
          state_next = MTTC_DONE;
        end else if (eval_reg && !below_fast) begin
          state_next = MTTC_SLOW;
        end
      end
      MTTC_SLOW: begin
        if (pause_req) begin
          state_next = MTTC_PAUSED;
        end else if (eval_reg && !below_final) begin
          state_next = MTTC_DONE;
        end
      end
      MTTC_PAUSED: begin
        if (abort_req) begin
          state_next = MTTC_IDLE;
        end else if (resume_req) begin
          state_next = resume_reg;
        end
      end
      default: begin
        state_next = MTTC_IDLE;
      end
    endcase
    if (!mode_latched) begin
      state_next = MTTC_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= MTTC_IDLE;
      resume_reg <= MTTC_SLOW;
    end else begin
      state_reg <= state_next;
      if (state_next == MTTC_PAUSED && state_reg != MTTC_PAUSED) resume_reg <= state_reg;
    end
  end

  // ==========================================================================
  // Feed outputs
  // ==========================================================================
  // The coincidence feed output holds its level on an exact match (fast feed drops), so the feeder
  // does not chatter when the weight sits right on the final cutoff.
  logic coin_fast;
  logic coin_feed;

  always_comb begin
    coin_fast = fast_reg;
    coin_feed = feed_reg;
    if (eval_reg) begin
      coin_fast = two_speed && below_fast;
      if (below_final) begin
        coin_feed = 1'b1;
      end else if (above_final) begin
        coin_feed = 1'b0;
      end
      if (two_speed && independent && coin_fast) begin
        coin_feed = 1'b0;
      end
    end
  end

  always_comb begin
    if (!mode_latched) begin
      fast_next = coin_fast;
      feed_next = coin_feed;
    end else begin
      case (state_next)
        MTTC_RAPID: begin
          fast_next = 1'b1;
          feed_next = !independent;
        end
        MTTC_SLOW: begin
          fast_next = 1'b0;
          feed_next = 1'b1;
        end
        default: begin
          fast_next = 1'b0;
          feed_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      feed_reg <= 1'b0;
      fast_reg <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      feed_reg <= feed_next;
      fast_reg <= fast_next && two_speed;
      running_reg <= (state_next == MTTC_RAPID) || (state_next == MTTC_SLOW);
    end
  end

  assign feed_out = feed_reg;
  assign fast_feed_out = fast_reg;
  assign running_out = running_reg;

  // ==========================================================================
  // Register reads
  // ==========================================================================
  always_comb begin
    rdata_next = 32'h00000000;
    if (!reg_rd) begin
      rdata_next = 32'h00000000;
    end else if (mttc_hit(reg_addr, `MTTC_OFS_CTRL)) begin
      rdata_next = {27'h0, ctrl_reg};
    end else if (mttc_hit(reg_addr, `MTTC_OFS_TARGET)) begin
      rdata_next = {8'h00, target_reg};
    end else if (mttc_hit(reg_addr, `MTTC_OFS_SPILL)) begin
      rdata_next = {8'h00, spill_reg};
    end else if (mttc_hit(reg_addr, `MTTC_OFS_FINE)) begin
      rdata_next = {8'h00, fine_reg};
    end else if (mttc_hit(reg_addr, `MTTC_OFS_STATUS)) begin
      rdata_next = {25'h0, above_final, fast_reg, feed_reg, 1'b0, state_reg};
    end else if (mttc_hit(reg_addr, `MTTC_OFS_WEIGHT)) begin
      rdata_next = {{6{sample_reg[`MTTC_AR_W-1]}}, sample_reg};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

//--- hw/mttc_cfg.svh
`ifndef MTTC_CFG_SVH
`define MTTC_CFG_SVH

// ==========================================================================
// Clock and comparison rate
// ==========================================================================
`define MTTC_CLK_HZ 100000000
`define MTTC_CMP_RATE_HZ 50
`define MTTC_TICK_CYCLES (`MTTC_CLK_HZ / `MTTC_CMP_RATE_HZ)

// ==========================================================================
// Widths
// ==========================================================================
`define MTTC_ADDR_W 8
`define MTTC_DATA_W 32
`define MTTC_WT_W 24
`define MTTC_AR_W 26
`define MTTC_PIN_N 4

// ==========================================================================
// Register offsets
// ==========================================================================
`define MTTC_OFS_CTRL 8'h00
`define MTTC_OFS_TARGET 8'h04
`define MTTC_OFS_SPILL 8'h08
`define MTTC_OFS_FINE 8'h0C
`define MTTC_OFS_CMD 8'h10
`define MTTC_OFS_STATUS 8'h14
`define MTTC_OFS_WEIGHT 8'h18

// ==========================================================================
// Field positions
// ==========================================================================
`define MTTC_CTRL_LATCHED 0
`define MTTC_CTRL_USE_NET 1
`define MTTC_CTRL_TWO_SPEED 2
`define MTTC_CTRL_INDEP 3
`define MTTC_CTRL_WEIGH_OUT 4
`define MTTC_CTRL_W 5
`define MTTC_CMD_START 0
`define MTTC_CMD_PAUSE 1
`define MTTC_CMD_RESUME 2
`define MTTC_CMD_ABORT 3

// ==========================================================================
// Reset values
// ==========================================================================
`define MTTC_CTRL_RST 5'h0
`define MTTC_WT_RST 24'h000000

`endif

//--- hw/mttc_pkg.sv
package mttc_pkg;

  // ==========================================================================
  // Feeder sequence states
  // ==========================================================================
  typedef enum logic [2:0] {
    MTTC_IDLE = 3'b000,
    MTTC_RAPID = 3'b001,
    MTTC_SLOW = 3'b010,
    MTTC_PAUSED = 3'b011,
    MTTC_DONE = 3'b100
  } mttc_state_type;

endpackage

//--- hw/mttc_tick.sv
`timescale 1ns/10ps

module mttc_tick #(
  parameter int unsigned PERIOD = 2000000
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  output logic tick
);

  // ==========================================================================
  // Free running divider
  // ==========================================================================
  logic [31:0] count_reg;
  logic tick_reg;
  logic wrap;

  assign wrap = (count_reg == 32'(PERIOD - 1));
  assign tick = tick_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= wrap ? 32'h00000000 : count_reg + 32'h00000001;
      tick_reg <= wrap;
    end
  end

endmodule

//--- verification/mttc_feeder_model.sv
`timescale 1ns/10ps
`include "mttc_cfg.svh"
// ==========================================================================
// Feeder and scale: material moves only while a feed output is on
// ==========================================================================
module mttc_feeder_model #(
  parameter int FAST_STEP = 3,
  parameter int SLOW_STEP = 1,
  parameter int TARE = 50
) (
  input wire logic ref_clk,
  input wire logic feed,
  input wire logic fast_feed,
  input wire logic drain,
  input wire logic load,
  input wire logic signed [23:0] load_val,
  output logic signed [23:0] gross_weight,
  output logic signed [23:0] net_weight
);
  logic signed [23:0] step;
  // No spill is modelled, so the scale stops the cycle the output drops.
  assign step = (fast_feed ? 24'(FAST_STEP) : 24'h000000) + (feed ? 24'(SLOW_STEP) : 24'h000000);
  assign net_weight = gross_weight - 24'(TARE);
  always @(posedge ref_clk) begin
    if (load)
      gross_weight <= load_val;
    else
      gross_weight <= drain ? gross_weight - step : gross_weight + step;
  end
endmodule

//--- verification/mttc_ctrl_assertions.sv
`timescale 1ns/10ps
`include "mttc_cfg.svh"
// ==========================================================================
// Port checker
// ==========================================================================
module mttc_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic signed [23:0] gross_weight,
  input wire logic signed [23:0] net_weight,
  input wire logic start_pin,
  input wire logic feed_out,
  input wire logic fast_feed_out,
  input wire logic running_out
);
  logic [4:0] ctrl_reg;
  logic signed [23:0] tgt_reg;
  logic signed [23:0] spill_reg;
  logic [3:0] since_reg;
  wire cmd_wr = reg_wr && reg_addr == `MTTC_OFS_CMD;
  wire go = (cmd_wr && (reg_wdata[0] || reg_wdata[2])) || start_pin;
  wire latched = ctrl_reg[0];
  wire conc = ctrl_reg[0] && ctrl_reg[2] && !ctrl_reg[3];
  wire signed [23:0] cmp_wt = ctrl_reg[1] ? net_weight : gross_weight;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Shadows of software writes tell the checker which mode is active.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `MTTC_CTRL_RST;
      tgt_reg <= 24'h000000;
      spill_reg <= 24'h000000;
      since_reg <= 4'hF;
    end else begin
      if (reg_wr && reg_addr == `MTTC_OFS_CTRL)
        ctrl_reg <= reg_wdata[4:0];
      if (reg_wr && reg_addr == `MTTC_OFS_TARGET)
        tgt_reg <= reg_wdata[23:0];
      if (reg_wr && reg_addr == `MTTC_OFS_SPILL)
        spill_reg <= reg_wdata[23:0];
      since_reg <= go ? 4'h0 : (since_reg == 4'hF ? since_reg : since_reg + 4'h1);
    end
  end
  a_indep_one_out: assert property (ctrl_reg[3] && ctrl_reg[2] |-> !(feed_out && fast_feed_out))
    else $error("both feeds on in independent mode");
  a_single_no_fast: assert property (!ctrl_reg[2] |-> !fast_feed_out)
    else $error("fast feed on in single speed");
  a_pause_drops: assert property (latched && cmd_wr && reg_wdata[1] && running_out |=> !feed_out && !fast_feed_out)
    else $error("pause left a feed on");
  a_rise_needs_cmd: assert property (latched && $rose(running_out) |-> since_reg <= 4'h6)
    else $error("latched run began without a command");
  a_conc_start: assert property (conc && $rose(fast_feed_out) |-> feed_out)
    else $error("concurrent start without slow feed");
  a_conc_switch: assert property (conc && $fell(fast_feed_out) && running_out |-> feed_out)
    else $error("slow feed dropped at switchover");
  a_coin_off: assert property (!latched && $fell(feed_out) |-> $past(cmp_wt) > tgt_reg - spill_reg)
    else $error("coincidence feed dropped below cutoff");
  a_run_feeds: assert property (latched && running_out |-> feed_out || fast_feed_out)
    else $error("running with no feed on");
  c_switch: cover property (conc && $fell(fast_feed_out) && running_out);
  c_coin: cover property (!latched && $rose(feed_out));
  c_pause: cover property (cmd_wr && reg_wdata[1] && running_out);
endmodule

//--- verification/mttc_ctrl_test.sv
`timescale 1ns/10ps
`include "mttc_cfg.svh"
// ==========================================================================
// Bench for the target comparison controller
// ==========================================================================
module mttc_ctrl_test;
  import mttc_pkg::*;
  localparam int TICK = 20;
  localparam logic [31:0] SM = 32'hFFFFFFBF;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [23:0] gross_weight;
  logic signed [23:0] net_weight;
  logic [3:0] pins = 4'h0;
  logic feed_out;
  logic fast_feed_out;
  logic running_out;
  logic drain = 1'b0;
  logic load = 1'b1;
  logic signed [23:0] load_val = 24'h000000;
  logic rd_seen = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  int num_errors = 0;
  int checks_done = 0;
  int tgt;
  int spill;
  int fine;
  int thr;

  always #5 ref_clk = ~ref_clk;

  mttc_ctrl #(.TICK_CYCLES(TICK)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gross_weight(gross_weight), .net_weight(net_weight), .start_pin(pins[0]), .pause_pin(pins[1]),
    .resume_pin(pins[2]), .abort_pin(pins[3]), .feed_out(feed_out), .fast_feed_out(fast_feed_out),
    .running_out(running_out));
  mttc_feeder_model u_feed (.ref_clk(ref_clk), .feed(feed_out), .fast_feed(fast_feed_out), .drain(drain),
    .load(load), .load_val(load_val), .gross_weight(gross_weight), .net_weight(net_weight));

  // ==========================================================================
  // Result checking
  // ==========================================================================
  task automatic check_word(input logic [31:0] got);
    logic [31:0] e;
    logic [31:0] m;
    e = exp_q.pop_front();
    m = mask_q.pop_front();
    checks_done++;
    if (((got ^ e) & m) !== 32'h0) begin
      num_errors++;
      $display("BAD reg_rdata expected %h seen %h", e, got);
    end
  endtask
  task automatic check_bit(input string name, input logic e, input logic got);
    checks_done++;
    if (got !== e) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", name, e, got);
    end
  endtask
  // Read data stand only in the cycle after the strobe.
  always @(posedge ref_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen)
      check_word(reg_rdata);
  end

  // ==========================================================================
  // Drivers
  // ==========================================================================
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    reg_addr <= a;
    reg_wdata <= 32'(d);
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Pins pass two synchronisers, so a pulse is held for three edges.
  task automatic cmd(input int b, input bit pin);
    if (pin) begin
      pins[b] <= 1'b1;
      cyc(3);
      pins[b] <= 1'b0;
      cyc(1);
    end else
      wr(`MTTC_OFS_CMD, 1 << b);
  endtask
  task automatic set_wt(input int w);
    load_val <= 24'(w);
    load <= 1'b1;
    cyc(1);
    load <= 1'b0;
  endtask
  task automatic wait_out(input bit fast, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((fast ? fast_feed_out : feed_out) !== v && n < 3000);
    check_bit("feed_wait", v, fast ? fast_feed_out : feed_out);
    @(posedge ref_clk);
  endtask
  function automatic logic [31:0] st(input mttc_state_type s, input logic fd, input logic fs);
    return {26'h0, fs, fd, 1'b0, 3'(s)};
  endfunction
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #300000;
    num_errors++;
    report_and_stop();
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    void'($urandom(32'hF97C9985));
    tgt = 900 + int'($urandom % 200);
    spill = 40 + int'($urandom % 40);
    fine = 100 + int'($urandom % 100);
    thr = tgt - spill;
    cyc(10);
    reset_n <= 1'b1;
    load <= 1'b0;
    cyc(1);
    rd(`MTTC_OFS_CTRL, 32'h0, '1);
    rd(`MTTC_OFS_STATUS, 32'h0, SM);
    rd(8'h1C, 32'h0, '1);
    rd(`MTTC_OFS_CMD, 32'h0, '1);
    wr(`MTTC_OFS_TARGET, tgt);
    wr(`MTTC_OFS_SPILL, spill);
    wr(`MTTC_OFS_FINE, fine);
    wait_out(0, 1'b1);
    check_bit("fast_unused", 1'b0, fast_feed_out);
    wait_out(0, 1'b0);
    check_bit("above_cut", 1'b1, int'(gross_weight) > thr);
    wr(`MTTC_OFS_CTRL, 32'h05);
    set_wt(0);
    cyc(3 * TICK);
    rd(`MTTC_OFS_STATUS, 32'h0, SM);
    cmd(0, 0);
    rd(`MTTC_OFS_STATUS, st(MTTC_RAPID, 1, 1), SM);
    wait_out(1, 1'b0);
    check_bit("feed_kept", 1'b1, feed_out);
    check_bit("fast_cut", 1'b1, int'(gross_weight) >= thr - fine);
    rd(`MTTC_OFS_STATUS, st(MTTC_SLOW, 1, 0), SM);
    cmd(1, 1);
    rd(`MTTC_OFS_STATUS, st(MTTC_PAUSED, 0, 0), SM);
    wr(`MTTC_OFS_TARGET, tgt + 300);
    cmd(2, 0);
    rd(`MTTC_OFS_STATUS, st(MTTC_SLOW, 1, 0), SM);
    wait_out(0, 1'b0);
    check_bit("old_target", 1'b1, int'(gross_weight) >= thr && int'(gross_weight) < thr + 60);
    rd(`MTTC_OFS_STATUS, st(MTTC_DONE, 0, 0), SM);
    set_wt(0);
    cyc(3 * TICK);
    rd(`MTTC_OFS_STATUS, st(MTTC_DONE, 0, 0), SM);
    wr(`MTTC_OFS_CTRL, 32'h0D);
    wr(`MTTC_OFS_TARGET, tgt);
    cmd(0, 1);
    rd(`MTTC_OFS_STATUS, st(MTTC_RAPID, 0, 1), SM);
    cmd(1, 0);
    rd(`MTTC_OFS_STATUS, st(MTTC_PAUSED, 0, 0), SM);
    cmd(3, 1);
    cmd(2, 0);
    rd(`MTTC_OFS_STATUS, 32'h0, SM);
    check_bit("stopped", 1'b0, running_out);
    wr(`MTTC_OFS_CTRL, 32'h03);
    set_wt(thr + 20);
    cmd(0, 0);
    rd(`MTTC_OFS_STATUS, st(MTTC_SLOW, 1, 0), SM);
    wait_out(0, 1'b0);
    check_bit("net_cut", 1'b1, int'(net_weight) >= thr);
    wr(`MTTC_OFS_CTRL, 32'h11);
    set_wt(3000);
    drain <= 1'b1;
    cmd(0, 0);
    wait_out(0, 1'b0);
    check_bit("removed", 1'b1, 3000 - int'(gross_weight) >= thr);
    cyc(2 * TICK);
    rd(`MTTC_OFS_WEIGHT, 32'(3000 - int'(gross_weight)), '1);
    drain <= 1'b0;
    wr(`MTTC_OFS_CTRL, 32'h0C);
    set_wt(0);
    wait_out(1, 1'b1);
    check_bit("indep_feed_off", 1'b0, feed_out);
    wait_out(1, 1'b0);
    check_bit("coin_fast_cut", 1'b1, int'(gross_weight) >= thr - fine);
    wait_out(0, 1'b1);
    wait_out(0, 1'b0);
    check_bit("coin_final", 1'b1, int'(gross_weight) > thr);
    cyc(2);
    report_and_stop();
  end
endmodule

bind mttc_ctrl mttc_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .gross_weight(gross_weight), .net_weight(net_weight), .start_pin(start_pin),
  .feed_out(feed_out), .fast_feed_out(fast_feed_out), .running_out(running_out));
